// [pkg/touch_consts.vh]
/*
  Constants of the touch sensor command and control logic: opcodes, register
  reset values, counter figures and timing counts.
  Assumes inclusion by bare name from the rtl files; definitions only.
*/
`ifndef TOUCH_CONSTS_VH
`define TOUCH_CONSTS_VH

// ----------------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------------
`define OP_RESTART 8'h00
`define OP_IRQ_RELEASE 8'h03
`define OP_SLEEP 8'h05
`define OP_RESUME 8'h06
`define OP_SETUP_STORE 8'h30
`define OP_SETUP_FETCH 8'h33
`define OP_OSC_STORE 8'h35
`define OP_OSC_FETCH 8'h36
`define OP_CHEN_STORE 8'h39
`define OP_CHEN_FETCH 8'h3A
`define OP_BUS_IRQ 8'h3C

// ----------------------------------------------------------------------------
// register reset values and fields
// ----------------------------------------------------------------------------
`define SETUP_RST 8'h00
`define OSC_RST 8'h0C
`define CHEN_RST 8'hFF
`define STATE_RST 8'h00
// osc register: coarse field bits 4:3, fine field bits 2:0
`define OSC_FREQ_MSB 4
// address base with the select bit as bit 0: 6'h1D gives 3Ah/3Bh
`define DEV_ADDR_BASE 6'h1D

// ----------------------------------------------------------------------------
// counter and timing
// ----------------------------------------------------------------------------
`define TOUCH_COUNT 7'h40
`define RATE_BASE 8'h40
// fast start-up after wake: 2000 ns at the 10 ns clock, sized for the counter
`define STARTUP_CYC 9'h0C8

`endif

// [rtl/touch_chan_array.v]
/*
  Eight per-channel pulse counters of the touch sensor; each declares a touch
  after a run of up pulses.
  Assumes up and down pulses are one-cycle strobes synchronous to the clock.
*/
`timescale 1ns/10ps
`include "touch_consts.vh"

module touch_chan_array (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_clear,
  input wire i_run,
  input wire [7:0] i_up_pulse,
  input wire [7:0] i_down_pulse,
  output wire [7:0] o_touch
);

  // --------------------------------------------------------------------------
  // one counter per channel
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : chan
      reg [6:0] count;
      reg last_up;
      reg hit;
      // each channel owns its flag so no vector has several drivers
      assign o_touch[g] = hit;
      // count saturates at the threshold so a held touch stays active
      always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
          count <= 7'h00;
          last_up <= 1'b0;
          hit <= 1'b0;
        end else if (i_clear) begin
          count <= 7'h00;
          last_up <= 1'b0;
          hit <= 1'b0;
        end else if (i_run && i_up_pulse[g] && !i_down_pulse[g]) begin
          if (!last_up) begin
            count <= 7'h01;
          end else if (count != `TOUCH_COUNT) begin
            count <= count + 7'h01;
          end
          last_up <= 1'b1;
          if (last_up && count == `TOUCH_COUNT - 7'h01) begin
            hit <= 1'b1;
          end
        end else if (i_run && i_down_pulse[g] && !i_up_pulse[g]) begin
          if (last_up) begin
            count <= 7'h01;
          end else if (count != `TOUCH_COUNT) begin
            count <= count + 7'h01;
          end
          last_up <= 1'b0;
          hit <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// [rtl/touch_sensor_command_control.v]
/*
  Command interpreter and control of the eight-channel touch sensor: opcode
  decode, sleep and wake, sample-rate tick, sensor state and interrupt.
  Assumes an external byte-level serial target front end that presents each
  received byte as a one-cycle strobe and requests read bytes by strobe.
*/
`timescale 1ns/10ps
`include "touch_consts.vh"

module touch_sensor_command_control (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_start,
  input wire i_stop,
  input wire i_rx_valid,
  input wire [7:0] i_rx_byte,
  input wire i_tx_req,
  input wire i_sleep_pin,
  input wire i_addr_select_pin,
  input wire i_cascade_turn,
  input wire [7:0] i_up_pulse,
  input wire [7:0] i_down_pulse,
  output reg o_addr_match,
  output reg [7:0] o_tx_byte,
  output reg o_tx_valid,
  output reg o_tx_drive,
  output reg [7:0] o_sensor_state_register,
  output reg [7:0] o_setup_register,
  output reg [7:0] o_clock_setting_register,
  output reg [7:0] o_channel_enable_register,
  output reg o_irq_output_pin_n,
  output reg o_bus_irq_mode,
  output reg o_bus_irq_pending,
  output reg o_osc_enable,
  output reg o_analog_enable,
  output reg o_regulator_enable,
  output reg o_fast_start,
  output reg o_sample_tick
);

  // --------------------------------------------------------------------------
  // transaction states
  // --------------------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_OPCODE = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_READ = 3'h4;
  localparam ST_SKIP = 3'h5;

  reg [2:0] state;
  reg [7:0] pend_op;
  reg sw_sleep;
  reg soft_clear;
  reg [8:0] startup_cnt;
  reg [7:0] rate_cnt;
  reg tx_second;
  reg fetch_armed;
  wire asleep;
  wire run;
  wire [7:0] touch;
  wire [7:0] next_state_reg;
  wire [6:0] my_addr;
  wire [7:0] rate_div;

  // sleep is the union of two sources; the resume opcode clears the opcode source only while the pin is low
  assign asleep = sw_sleep | i_sleep_pin;
  assign run = !asleep && (startup_cnt == 9'h000) && !soft_clear;
  assign my_addr = {`DEV_ADDR_BASE, i_addr_select_pin};
  // masked channels read as zero in the state register
  assign next_state_reg = touch & o_channel_enable_register;
  // higher frequency setting gives a shorter divider
  assign rate_div = `RATE_BASE - {3'h0, o_clock_setting_register[`OSC_FREQ_MSB:0]};

  touch_chan_array u_chan (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_clear(soft_clear),
    .i_run(run),
    .i_up_pulse(i_up_pulse),
    .i_down_pulse(i_down_pulse),
    .o_touch(touch)
  );

  // --------------------------------------------------------------------------
  // command decode and register writes
  // --------------------------------------------------------------------------
  // the restart request is held one cycle so the channel array clears with it
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      pend_op <= 8'h00;
      sw_sleep <= 1'b0;
      soft_clear <= 1'b0;
      o_addr_match <= 1'b0;
      o_setup_register <= `SETUP_RST;
      o_clock_setting_register <= `OSC_RST;
      o_channel_enable_register <= `CHEN_RST;
      o_bus_irq_mode <= 1'b0;
      tx_second <= 1'b0;
      fetch_armed <= 1'b0;
    end else begin
      soft_clear <= 1'b0;
      if (i_start) begin
        state <= ST_ADDR;
        o_addr_match <= 1'b0;
      end else if (i_stop) begin
        state <= ST_IDLE;
        o_addr_match <= 1'b0;
        fetch_armed <= 1'b0;
      end else if (i_rx_valid) begin
        case (state)
          ST_ADDR: begin
            fetch_armed <= 1'b0;
            if (i_rx_byte[7:1] != my_addr) begin
              state <= ST_SKIP;
            end else if (i_rx_byte[0]) begin
              state <= ST_READ;
              o_addr_match <= 1'b1;
              // a read right after a fetch opcode answers that fetch
              if (!fetch_armed) begin
                pend_op <= 8'hFF;
              end
              tx_second <= 1'b0;
            end else begin
              state <= ST_OPCODE;
              o_addr_match <= 1'b1;
            end
          end
          ST_OPCODE: begin
            pend_op <= i_rx_byte;
            state <= ST_SKIP;
            case (i_rx_byte)
              `OP_RESTART: begin
                soft_clear <= 1'b1;
                sw_sleep <= 1'b0;
                o_setup_register <= `SETUP_RST;
                o_clock_setting_register <= `OSC_RST;
                o_channel_enable_register <= `CHEN_RST;
                o_bus_irq_mode <= 1'b0;
              end
              `OP_SLEEP: begin
                // pin sleep already active: the opcode sleep still latches
                sw_sleep <= 1'b1;
              end
              `OP_RESUME: begin
                if (!i_sleep_pin) begin
                  sw_sleep <= 1'b0;
                end
              end
              `OP_BUS_IRQ: o_bus_irq_mode <= 1'b1;
              `OP_SETUP_STORE, `OP_OSC_STORE, `OP_CHEN_STORE: state <= ST_DATA;
              `OP_SETUP_FETCH, `OP_OSC_FETCH, `OP_CHEN_FETCH: begin
                state <= ST_OPCODE;
                fetch_armed <= 1'b1;
              end
              default: state <= ST_SKIP;
            endcase
          end
          ST_DATA: begin
            state <= ST_SKIP;
            case (pend_op)
              `OP_SETUP_STORE: o_setup_register <= i_rx_byte;
              `OP_OSC_STORE: o_clock_setting_register <= i_rx_byte;
              `OP_CHEN_STORE: o_channel_enable_register <= i_rx_byte;
              default: state <= ST_SKIP;
            endcase
          end
          default: state <= state;
        endcase
      end else if (i_tx_req && state == ST_READ) begin
        tx_second <= !tx_second;
      end
    end
  end

  // --------------------------------------------------------------------------
  // read data: fetch replies and state reads both repeat on every read request
  // --------------------------------------------------------------------------
  // fetch replies need a repeated start with read direction after the opcode;
  // the pending opcode survives the restart of the transaction
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_byte <= 8'h00;
      o_tx_valid <= 1'b0;
      o_tx_drive <= 1'b0;
    end else begin
      o_tx_valid <= 1'b0;
      if (i_stop || i_start) begin
        o_tx_drive <= 1'b0;
      end else if (i_tx_req && state == ST_READ) begin
        o_tx_valid <= 1'b1;
        // in a cascade the partner takes every other byte
        o_tx_drive <= !(i_cascade_turn && tx_second);
        case (pend_op)
          `OP_SETUP_FETCH: o_tx_byte <= o_setup_register;
          `OP_OSC_FETCH: o_tx_byte <= o_clock_setting_register;
          `OP_CHEN_FETCH: o_tx_byte <= o_channel_enable_register;
          default: o_tx_byte <= o_sensor_state_register;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // sensor state and interrupt
  // --------------------------------------------------------------------------
  // a change in the same cycle as a release wins, so no event is lost
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sensor_state_register <= `STATE_RST;
      o_irq_output_pin_n <= 1'b1;
      o_bus_irq_pending <= 1'b0;
    end else if (soft_clear) begin
      o_sensor_state_register <= `STATE_RST;
      o_irq_output_pin_n <= 1'b1;
      o_bus_irq_pending <= 1'b0;
    end else begin
      o_sensor_state_register <= next_state_reg;
      if (next_state_reg != o_sensor_state_register) begin
        o_irq_output_pin_n <= o_bus_irq_mode;
        o_bus_irq_pending <= o_bus_irq_mode;
      end else if ((i_rx_valid && state == ST_OPCODE && i_rx_byte == `OP_IRQ_RELEASE)) begin
        o_irq_output_pin_n <= 1'b1;
        o_bus_irq_pending <= 1'b0;
      end else if (i_tx_req && state == ST_READ && pend_op == 8'hFF) begin
        o_irq_output_pin_n <= 1'b1;
        o_bus_irq_pending <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // power control and start-up
  // --------------------------------------------------------------------------
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_osc_enable <= 1'b1;
      o_analog_enable <= 1'b1;
      o_regulator_enable <= 1'b1;
      o_fast_start <= 1'b1;
      startup_cnt <= `STARTUP_CYC;
    end else begin
      o_osc_enable <= !asleep;
      o_analog_enable <= !asleep;
      o_regulator_enable <= !asleep;
      if (asleep) begin
        startup_cnt <= `STARTUP_CYC;
        o_fast_start <= 1'b0;
      end else if (startup_cnt != 9'h000) begin
        startup_cnt <= startup_cnt - 9'h001;
        o_fast_start <= 1'b1;
      end else begin
        o_fast_start <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // sample rate tick
  // --------------------------------------------------------------------------
  // the tick stops with the oscillator, so sleep leaves no activity
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rate_cnt <= 8'h00;
      o_sample_tick <= 1'b0;
    end else if (!run) begin
      rate_cnt <= 8'h00;
      o_sample_tick <= 1'b0;
    end else if (rate_cnt >= rate_div - 8'h01) begin
      // counting 0 to divider-1 gives a tick every divider cycles
      rate_cnt <= 8'h00;
      o_sample_tick <= 1'b1;
    end else begin
      rate_cnt <= rate_cnt + 8'h01;
      o_sample_tick <= 1'b0;
    end
  end

endmodule

// [test/touch_ctl_properties.sv]
/* checker on the command control ports, bound to the top module.
   assumes byte strobes come one at a time, as the front end gives them. */
`timescale 1ns/10ps
`include "touch_consts.vh"
module touch_ctl_properties (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_start,
  input wire i_stop,
  input wire i_rx_valid,
  input wire [7:0] i_rx_byte,
  input wire i_tx_req,
  input wire o_addr_match,
  input wire o_tx_valid,
  input wire [7:0] o_sensor_state_register,
  input wire [7:0] o_clock_setting_register,
  input wire [7:0] o_channel_enable_register,
  input wire o_irq_output_pin_n,
  input wire o_bus_irq_mode,
  input wire o_osc_enable
);
  // ------
  // byte position and opcode tracking
  // ------
  reg [1:0] pos;
  reg [7:0] op;
  reg fetch;
  wire bv = i_rx_valid && o_addr_match && !i_start && !i_stop;
  wire opv = bv && pos == 2'h1;
  wire datv = bv && pos == 2'h2;
  wire op_rst = opv && i_rx_byte == `OP_RESTART;
  wire wr_osc = datv && op == `OP_OSC_STORE;
  wire osc_cause = wr_osc || op_rst;
  // fetch flag keeps register reads apart from state reads, which release the line
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pos <= 2'h0;
      op <= 8'hFF;
      fetch <= 1'b0;
    end else if (i_start || i_stop) begin
      pos <= 2'h0;
      fetch <= fetch && !i_stop;
    end else if (i_rx_valid) begin
      pos <= (pos == 2'h3) ? pos : pos + 2'h1;
      if (opv) begin
        op <= i_rx_byte;
        fetch <= i_rx_byte == `OP_SETUP_FETCH || i_rx_byte == `OP_OSC_FETCH
          || i_rx_byte == `OP_CHEN_FETCH;
      end
    end
  end
  default clocking dc @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  a_restart_regs: assert property (
    op_rst |=> o_clock_setting_register == `OSC_RST && !o_bus_irq_mode
      && o_channel_enable_register == `CHEN_RST) else $error("restart left state");
  a_irq_release: assert property (
    opv && i_rx_byte == `OP_IRQ_RELEASE
      |=> o_irq_output_pin_n || $changed(o_sensor_state_register)) else $error("irq kept");
  a_sleep_power: assert property (
    opv && i_rx_byte == `OP_SLEEP |-> ##[1:2] !o_osc_enable) else $error("osc still on");
  a_bus_mode: assert property (
    opv && i_rx_byte == `OP_BUS_IRQ |=> o_bus_irq_mode) else $error("bus irq mode off");
  a_store_osc: assert property (
    wr_osc |=> o_clock_setting_register == $past(i_rx_byte)) else $error("osc not stored");
  a_store_mask: assert property (
    datv && op == `OP_CHEN_STORE |=> o_channel_enable_register == $past(i_rx_byte))
    else $error("mask not stored");
  a_osc_guard: assert property (
    $changed(o_clock_setting_register) |-> $past(osc_cause)) else $error("osc changed");
  a_read_answer: assert property (
    i_tx_req && o_addr_match |=> o_tx_valid) else $error("no read answer");
  a_read_frees: assert property (
    i_tx_req && o_addr_match && !fetch
      |=> o_irq_output_pin_n || $changed(o_sensor_state_register)) else $error("irq held");
  a_change_irq: assert property (
    $changed(o_sensor_state_register) && !o_bus_irq_mode && !$past(op_rst, 2)
      |-> ##[0:2] !o_irq_output_pin_n) else $error("no irq on change");
endmodule
bind touch_sensor_command_control touch_ctl_properties u_props (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_start(i_start), .i_stop(i_stop),
  .i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte), .i_tx_req(i_tx_req),
  .o_addr_match(o_addr_match), .o_tx_valid(o_tx_valid),
  .o_sensor_state_register(o_sensor_state_register),
  .o_clock_setting_register(o_clock_setting_register),
  .o_channel_enable_register(o_channel_enable_register),
  .o_irq_output_pin_n(o_irq_output_pin_n), .o_bus_irq_mode(o_bus_irq_mode),
  .o_osc_enable(o_osc_enable)
);

// [test/bus_master_model.sv]
/* bus controller model giving byte strobes and read requests.
   assumes read data answers within three cycles. */
`timescale 1ns/10ps
module bus_master_model (
  input wire i_sys_clk,
  input wire i_tx_valid,
  input wire [7:0] i_tx_byte,
  input wire i_tx_drive,
  output reg o_start,
  output reg o_stop,
  output reg o_rx_valid,
  output reg [7:0] o_rx_byte,
  output reg o_tx_req
);
  // idle bus at time zero
  initial begin
    {o_start, o_stop, o_rx_valid, o_tx_req} = 4'h0;
    o_rx_byte = 8'h00;
  end
  // kind 0 start, 1 stop, 2 byte, 3 read request; released data is inverted
  // so a stale byte can never look valid
  task pulse(input [1:0] kind, input [7:0] b);
    begin
      @(negedge i_sys_clk);
      o_start = kind == 2'h0;
      o_stop = kind == 2'h1;
      o_rx_valid = kind == 2'h2;
      o_tx_req = kind == 2'h3;
      o_rx_byte = b;
      @(negedge i_sys_clk);
      {o_start, o_stop, o_rx_valid, o_tx_req} = 4'h0;
      o_rx_byte = ~b;
    end
  endtask
  // a missing answer comes back as unknown data
  task read_byte(output [7:0] d, output drv);
    integer k;
    begin
      pulse(2'h3, 8'h00);
      k = 0;
      while (k < 3 && i_tx_valid !== 1'b1) begin
        @(negedge i_sys_clk);
        k = k + 1;
      end
      d = (i_tx_valid === 1'b1) ? i_tx_byte : 8'hXX;
      drv = i_tx_drive;
    end
  endtask
endmodule

// [test/tb_top.sv]
/* top bench for the command control, driven through the bus model.
   assumes device address 3Ah with the select pin low, 3Bh with it high. */
`timescale 1ns/10ps
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg slp = 1'b0;
  reg turn = 1'b0;
  reg asel = 1'b0;
  reg [7:0] up = 8'h00;
  reg [7:0] dn = 8'h00;
  reg [7:0] d;
  reg drv;
  integer err_total = 0;
  integer checks = 0;
  integer cycles = 0;
  integer k;
  wire st, sp, rv, tq, am, tv, td, irq_n, bm, oe, ae, re, fs, bp, tk;
  wire [7:0] rxb, txb, ss, su, cs, ce;
  // ------
  // clock, design and partner
  // ------
  always #5 clk = ~clk;
  touch_sensor_command_control dut (
    .i_sys_clk(clk), .i_rst(rst), .i_start(st), .i_stop(sp), .i_rx_valid(rv),
    .i_rx_byte(rxb), .i_tx_req(tq), .i_sleep_pin(slp), .i_addr_select_pin(asel),
    .i_cascade_turn(turn), .i_up_pulse(up), .i_down_pulse(dn), .o_addr_match(am),
    .o_tx_byte(txb), .o_tx_valid(tv), .o_tx_drive(td), .o_sensor_state_register(ss),
    .o_setup_register(su), .o_clock_setting_register(cs), .o_channel_enable_register(ce),
    .o_irq_output_pin_n(irq_n), .o_bus_irq_mode(bm), .o_bus_irq_pending(bp),
    .o_osc_enable(oe), .o_analog_enable(ae), .o_regulator_enable(re),
    .o_fast_start(fs), .o_sample_tick(tk));
  bus_master_model m (.i_sys_clk(clk), .i_tx_valid(tv), .i_tx_byte(txb),
    .i_tx_drive(td), .o_start(st), .o_stop(sp), .o_rx_valid(rv), .o_rx_byte(rxb),
    .o_tx_req(tq));
  // ------
  // shared tasks
  // ------
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // address byte is the 7-bit device address then the direction bit
  task wr_at(input [7:0] a, input [7:0] op, input [7:0] dat, input has_d);
    begin
      m.pulse(2'h0, 8'h00);
      m.pulse(2'h2, a);
      m.pulse(2'h2, op);
      if (has_d) m.pulse(2'h2, dat);
      m.pulse(2'h1, 8'h00);
    end
  endtask
  task wr(input [7:0] op, input [7:0] dat, input has_d);
    wr_at(8'h74, op, dat, has_d);
  endtask
  // fetch: opcode, then repeated start and read address
  task rd(input [7:0] op);
    begin
      m.pulse(2'h0, 8'h00);
      m.pulse(2'h2, 8'h74);
      m.pulse(2'h2, op);
      m.pulse(2'h0, 8'h00);
      m.pulse(2'h2, 8'h75);
      m.read_byte(d, drv);
      m.pulse(2'h1, 8'h00);
    end
  endtask
  task pulse_ch(input is_up);
    begin
      @(negedge clk);
      up = {7'h00, is_up};
      dn = {7'h00, !is_up};
      @(negedge clk);
      up = 8'h00;
      dn = 8'h00;
    end
  endtask
  task settle;
    repeat (3) @(negedge clk);
  endtask
  // cycles from one sample tick to the next
  task t_rate(input [7:0] want);
    integer n;
    begin
      n = 0;
      while (tk !== 1'b1 && n < 200) begin
        @(negedge clk);
        n = n + 1;
      end
      @(negedge clk);
      n = 1;
      while (tk !== 1'b1 && n < 200) begin
        @(negedge clk);
        n = n + 1;
      end
      chk(n[7:0], want);
    end
  endtask
  // ------
  // scenarios
  // ------
  task t_regs;
    begin
      chk(su, 8'h00);
      chk(ss, 8'h00);
      chk({7'h00, irq_n}, 8'h01);
      chk(cs, 8'h0C);
      chk(ce, 8'hFF);
      wr(8'h30, 8'hA5, 1'b1);
      rd(8'h33);
      chk(d, 8'hA5);
      wr(8'h35, 8'h13, 1'b1);
      rd(8'h36);
      chk(d, 8'h13);
      wr(8'h39, 8'h5A, 1'b1);
      rd(8'h3A);
      chk(d, 8'h5A);
      wr(8'h7E, 8'h00, 1'b1);
      chk(cs, 8'h13);
      chk(ce, 8'h5A);
      chk(su, 8'hA5);
      wr_at(8'h76, 8'h35, 8'h00, 1'b1);
      chk(cs, 8'h13);
      asel = 1'b1;
      wr_at(8'h76, 8'h35, 8'h00, 1'b1);
      asel = 1'b0;
      chk(cs, 8'h00);
      wr(8'h3C, 8'h00, 1'b0);
      chk({7'h00, bm}, 8'h01);
      wr(8'h00, 8'h00, 1'b0);
      chk(su, 8'h00);
      chk({7'h00, bm}, 8'h00);
      chk(cs, 8'h0C);
      chk(ce, 8'hFF);
    end
  endtask
  // one down pulse mid-run restarts the count of up pulses
  task t_touch;
    begin
      for (k = 0; k < 400 && fs !== 1'b0; k = k + 1) @(negedge clk);
      // reset clock setting 0Ch gives a divider of 64 - 12
      t_rate(8'h34);
      for (k = 0; k < 127; k = k + 1) pulse_ch(k != 63);
      settle;
      chk(ss, 8'h00);
      pulse_ch(1'b1);
      settle;
      chk(ss, 8'h01);
      chk({7'h00, irq_n}, 8'h00);
      m.pulse(2'h0, 8'h00);
      m.pulse(2'h2, 8'h75);
      m.read_byte(d, drv);
      chk(d, 8'h01);
      chk({7'h00, irq_n}, 8'h01);
      m.read_byte(d, drv);
      chk(d, 8'h01);
      m.pulse(2'h1, 8'h00);
      turn = 1'b1;
      m.pulse(2'h0, 8'h00);
      m.pulse(2'h2, 8'h75);
      m.read_byte(d, drv);
      chk({7'h00, drv}, 8'h01);
      m.read_byte(d, drv);
      chk({7'h00, drv}, 8'h00);
      m.pulse(2'h1, 8'h00);
      turn = 1'b0;
      wr(8'h39, 8'h00, 1'b1);
      chk({7'h00, irq_n}, 8'h00);
      wr(8'h03, 8'h00, 1'b0);
      chk({7'h00, irq_n}, 8'h01);
      // bus signalled mode: a change marks pending and leaves the pin high
      wr(8'h3C, 8'h00, 1'b0);
      wr(8'h39, 8'h01, 1'b1);
      settle;
      chk({6'h00, bp, irq_n}, 8'h03);
      m.pulse(2'h0, 8'h00);
      m.pulse(2'h2, 8'h75);
      m.read_byte(d, drv);
      chk(d, 8'h01);
      chk({7'h00, bp}, 8'h00);
      m.pulse(2'h1, 8'h00);
    end
  endtask
  task t_sleep;
    begin
      wr(8'h05, 8'h00, 1'b0);
      chk({5'h00, oe, ae, re}, 8'h00);
      slp = 1'b1;
      settle;
      slp = 1'b0;
      settle;
      chk({7'h00, oe}, 8'h00);
      wr(8'h35, 8'h0A, 1'b1);
      rd(8'h36);
      chk(d, 8'h0A);
      wr(8'h06, 8'h00, 1'b0);
      chk({4'h0, fs, oe, ae, re}, 8'h0F);
      slp = 1'b1;
      settle;
      chk({7'h00, oe}, 8'h00);
      wr(8'h06, 8'h00, 1'b0);
      chk({7'h00, oe}, 8'h00);
      slp = 1'b0;
      settle;
      chk({7'h00, oe}, 8'h01);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // hang guard: the run needs well under 5000 cycles
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      summarize;
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_regs;
    t_touch;
    t_sleep;
    summarize;
  end
endmodule
